// ### logic/pcirq_cfg.svh
// Purpose: Offsets, field positions and reset values of the socket
//          interrupt event block.
// Assumes: Byte-wide register port with 8-bit offsets.
// Notes:   Definitions only.
`ifndef PCIRQ_CFG_SVH
`define PCIRQ_CFG_SVH

`define PCIRQ_OFS_CSC_FLAGS  8'h04
`define PCIRQ_OFS_CSC_CFG    8'h05
`define PCIRQ_OFS_GLOBAL     8'h1E
`define PCIRQ_OFS_SOCK_EVENT 8'h60
`define PCIRQ_OFS_SOCK_MASK  8'h61
`define PCIRQ_OFS_ROUTING    8'h8C
`define PCIRQ_OFS_CARD_CTRL  8'h91
`define PCIRQ_OFS_SB_DATA    8'hB0
`define PCIRQ_OFS_SB_INDEX   8'hB1
`define PCIRQ_OFS_SB_TARGET  8'hB2
`define PCIRQ_OFS_SB_CTRL    8'hB3

`define PCIRQ_BIT_BATT0      0
`define PCIRQ_BIT_BATT1      1
`define PCIRQ_BIT_READY      2
`define PCIRQ_BIT_PWR        3
`define PCIRQ_BIT_CSTS       0
`define PCIRQ_BIT_CD1        1
`define PCIRQ_BIT_CD2        2
`define PCIRQ_BIT_FCMS       2
`define PCIRQ_BIT_FUNC       0
`define PCIRQ_BIT_TIE        3
`define PCIRQ_BIT_SERMODE    7
`define PCIRQ_BIT_SB_VALID   0
`define PCIRQ_BIT_SB_ERR     1
`define PCIRQ_BIT_SB_PROT    3
`define PCIRQ_BIT_SB_BUSY    5
`define PCIRQ_BIT_SB_READ    0

`define PCIRQ_RST_BYTE       8'h00
`define PCIRQ_RST_ROUTING    8'h77
`define PCIRQ_TERM_NONE      3'h7

`endif

// ### logic/pcirq_pkg.sv
// Purpose: Types shared by the socket interrupt event block.
// Assumes: Nothing beyond the configuration header.
// Notes:   Pins are raw socket levels, card detects active low.
package pcirq_pkg;

   typedef enum logic [1:0] {
      PCIRQ_CT_NONE    = 2'h0,
      PCIRQ_CT_MEM16   = 2'h1,
      PCIRQ_CT_IO16    = 2'h2,
      PCIRQ_CT_CARDBUS = 2'h3
   } pcirq_card_e;

   typedef enum logic [1:0] {
      PCIRQ_SB_IDLE = 2'b01,
      PCIRQ_SB_BUSY = 2'b10
   } pcirq_sb_e;

   typedef struct packed {
      logic cd1_n;
      logic cd2_n;
      logic bvd1_sts;
      logic bvd2;
      logic ready_ireq;
   } pcirq_pins_s;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pcirq_reg_s;

   typedef struct packed {
      logic       start;
      logic [7:0] target;
      logic [7:0] index;
      logic [7:0] data;
      logic       prot;
   } pcirq_sb_req_s;

   typedef struct packed {
      logic       done;
      logic       err;
      logic [7:0] rdata;
   } pcirq_sb_rsp_s;

endpackage

// ### logic/pcirq_sync.sv
// Purpose: Two-stage synchroniser for the socket pins.
// Assumes: Pins change slowly compared with CLK.
// Notes:   The first stage feeds the second stage only.
`timescale 1ns/1ps
`default_nettype none
module pcirq_sync #(
   parameter int W = 5
) (
   input  wire logic         CLK,
   input  wire logic         RESETN,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
   } pcirq_sync_s;

   pcirq_sync_s st_r;
   pcirq_sync_s st_nxt;

   always_comb begin
      st_nxt      = st_r;
      st_nxt.meta = d;
      st_nxt.sync = st_r.meta;
   end

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign q = st_r.sync;
endmodule // pcirq_sync
`default_nettype wire

// ### logic/pcirq_sbus.sv
// Purpose: Serial-bus request holder behind the data and target registers.
// Assumes: An external engine answers each request with one done pulse.
// Notes:   A start while busy is ignored, so software must poll busy.
`timescale 1ns/1ps
`default_nettype none
`include "pcirq_cfg.svh"
module pcirq_sbus
   import pcirq_pkg::*;
(
   input  wire logic          CLK,
   input  wire logic          RESETN,
   input  wire logic          start,
   input  wire logic          data_wr,
   input  wire logic [7:0]    wdata,
   input  wire logic [7:0]    target,
   input  wire logic [7:0]    index,
   input  wire logic          prot,
   input  wire pcirq_sb_rsp_s rsp,
   output pcirq_sb_req_s      req,
   output logic               busy,
   output logic               valid,
   output logic               err,
   output logic [7:0]         data
);
   typedef struct packed {
      pcirq_sb_e     fsm;
      pcirq_sb_req_s req;
      logic [7:0]    data;
      logic          valid;
      logic          err;
   } pcirq_sbus_s;

   pcirq_sbus_s st_r;
   pcirq_sbus_s st_nxt;

   always_comb begin
      st_nxt           = st_r;
      st_nxt.req.start = 1'b0;
      if (data_wr) begin
         st_nxt.data = wdata;
      end
      unique case (st_r.fsm)
         PCIRQ_SB_IDLE: begin
            if (start) begin // [R18]
               st_nxt.req   = '{1'b1, target, index, st_nxt.data, prot};
               st_nxt.valid = 1'b0;
               st_nxt.err   = 1'b0;
               st_nxt.fsm   = PCIRQ_SB_BUSY;
            end
         end
         PCIRQ_SB_BUSY: begin
            if (rsp.done) begin
               st_nxt.fsm = PCIRQ_SB_IDLE;
               st_nxt.err = rsp.err;
               if (st_r.req.target[`PCIRQ_BIT_SB_READ] && !rsp.err) begin
                  st_nxt.data  = rsp.rdata;
                  st_nxt.valid = 1'b1;
               end
            end
         end
         default: st_nxt.fsm = PCIRQ_SB_IDLE;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         st_r     <= '0;
         st_r.fsm <= PCIRQ_SB_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign req   = st_r.req;
   assign busy  = st_r.fsm == PCIRQ_SB_BUSY;
   assign valid = st_r.valid;
   assign err   = st_r.err;
   assign data  = st_r.data;

   sb_start_a: // [R18]
      assert property (@(posedge CLK) disable iff (!RESETN)
         start && !busy |=> busy && req.start && req.target == $past(target))
      else $error("Target write did not start a serial-bus request.");

   sb_done_c: cover property (@(posedge CLK) disable iff (!RESETN)
      busy && rsp.done);
endmodule // pcirq_sbus
`default_nettype wire

// ### logic/pcirq_events.sv
// Purpose: Socket interrupt event detection, flags, masks and routing
//          onto the multifunction terminals.
// Assumes: Card type and power-done come from logic on CLK; pins do not.
// Notes:   Flags record events regardless of mask; masks gate the output.
`timescale 1ns/1ps
`default_nettype none
`include "pcirq_cfg.svh"

// Function
// R1 - Memory card battery events set flag bits 1:0, gated by config 1:0.
// R2 - Memory card ready change sets flag bit 2, gated by config bit 2.
// R3 - I/O card status-change sets flag bit 0, gated by config bit 0.
// R4 - Power cycle complete on 16-bit cards sets flag bit 3, gated bit 3.
// R5 - Functional requests are never masked; status shows in card control 0.
// R6 - CardBus status-change sets socket event bit 0, gated by mask bit 0.
// R7 - CardBus insert/remove sets event bits 2:1, power done bit 3, masked.
// R8 - Memory card: any battery detect line transition raises an event.
// R9 - Memory card: any ready line transition, either way, raises an event.
// R10 - I/O card: status-change assertion raises an event; release does not.
// R11 - CardBus card: status-change assertion raises an event.
// R12 - Interrupt line assertion by I/O or CardBus card is functional.
// R13 - Either card-detect transition raises insert/remove, any card type.
// R14 - Power cycle complete comes from the power sequencer, not a pin.
// R15 - Memory cards never produce functional interrupts.
// R16 - Parallel line-A interrupt works beside parallel or serial IRQs.
// R17 - All interrupt signalling leaves on seven multifunction terminals; serial-mode requests leave on the separate serial line instead.
// R18 - Writing the target address register starts a serial-bus request.
// R19 - 16-bit flags clear on read or write-one; global bit 2 picks.
// R20 - Socket event flags clear only by writing one.
// R21 - Terminal asserts while an enabled flag or functional request is set.
module pcirq_events
   import pcirq_pkg::*;
(
   input  wire logic          CLK,
   input  wire logic          RESETN,
   input  wire pcirq_pins_s   CARD_PINS,
   input  wire pcirq_card_e   CARD_TYPE,
   input  wire logic          PWR_DONE,
   input  wire pcirq_reg_s    REG,
   output logic [7:0]         REG_RDATA,
   output logic [6:0]         MULTIFUNCTION_TERMINALS,
   output logic               SERIALIZED_INTERRUPT_LINE,
   output pcirq_sb_req_s      SB_REQ,
   input  wire pcirq_sb_rsp_s SB_RSP
);
   typedef struct packed {
      pcirq_pins_s prev;
      logic [3:0]  csc_flags;
      logic [7:0]  csc_cfg;
      logic [7:0]  gctl;
      logic [3:0]  sev;
      logic [3:0]  smask;
      logic [7:0]  route;
      logic [6:0]  cctl;
      logic        func;
      logic [7:0]  rdata;
      logic [6:0]  mfunc;
      logic        serq;
      logic [7:0]  sb_index;
      logic [7:0]  sb_target;
      logic        sb_prot;
      logic        sb_go;
   } pcirq_events_s;

   pcirq_events_s st_r;
   pcirq_events_s st_nxt;
   pcirq_pins_s   cur;
   logic [4:0]    sync_q;
   logic          present;
   logic          mem;
   logic          io;
   logic          cb;
   logic          func_now;
   logic [3:0]    set_csc;
   logic [3:0]    set_sev;
   logic          csc_irq;
   logic          sb_busy;
   logic          sb_valid;
   logic          sb_err;
   logic [7:0]    sb_data;

   function automatic logic [6:0] term_onehot(input logic [2:0] sel,
                                              input logic       on);
      logic [6:0] one;
      one = 7'h01;
      return (on && sel != `PCIRQ_TERM_NONE) ? one << sel : 7'h00;
   endfunction

   // Pins are asynchronous, so two flops stand before any edge detection.
   pcirq_sync #(
      .W (5)
   ) pcirq_sync_i (
      .CLK    (CLK),
      .RESETN (RESETN),
      .d      (CARD_PINS),
      .q      (sync_q)
   );

   pcirq_sbus pcirq_sbus_i (
      .CLK     (CLK),
      .RESETN  (RESETN),
      .start   (st_r.sb_go),
      .data_wr (REG.wr && REG.addr == `PCIRQ_OFS_SB_DATA),
      .wdata   (REG.wdata),
      .target  (st_r.sb_target),
      .index   (st_r.sb_index),
      .prot    (st_r.sb_prot),
      .rsp     (SB_RSP),
      .req     (SB_REQ),
      .busy    (sb_busy),
      .valid   (sb_valid),
      .err     (sb_err),
      .data    (sb_data)
   );

   assign cur     = pcirq_pins_s'(sync_q);
   assign present = !cur.cd1_n && !cur.cd2_n;
   assign mem     = present && CARD_TYPE == PCIRQ_CT_MEM16;
   assign io      = present && CARD_TYPE == PCIRQ_CT_IO16;
   assign cb      = present && CARD_TYPE == PCIRQ_CT_CARDBUS;
   // The shared ready pin is an active-low request for I/O and CardBus.
   assign func_now = (io || cb) && !cur.ready_ireq; // [R12] [R15]

   always_comb begin
      set_csc = 4'h0;
      set_sev = 4'h0;
      set_csc[`PCIRQ_BIT_BATT0] =
         (mem && cur.bvd1_sts != st_r.prev.bvd1_sts) || // [R1] [R8]
         (io && st_r.prev.bvd1_sts && !cur.bvd1_sts);   // [R3] [R10]
      set_csc[`PCIRQ_BIT_BATT1] = mem && cur.bvd2 != st_r.prev.bvd2; // [R8]
      set_csc[`PCIRQ_BIT_READY] =
         mem && cur.ready_ireq != st_r.prev.ready_ireq; // [R2] [R9]
      set_csc[`PCIRQ_BIT_PWR] = PWR_DONE && (mem || io); // [R4] [R14]
      set_sev[`PCIRQ_BIT_CSTS] =
         cb && !st_r.prev.bvd1_sts && cur.bvd1_sts; // [R6] [R11]
      set_sev[`PCIRQ_BIT_CD1] = cur.cd1_n != st_r.prev.cd1_n; // [R7] [R13]
      set_sev[`PCIRQ_BIT_CD2] = cur.cd2_n != st_r.prev.cd2_n; // [R13]
      set_sev[`PCIRQ_BIT_PWR] = PWR_DONE && cb; // [R7] [R14]
   end

   // Masked events still set flags; unmasking later raises the line at once.
   assign csc_irq = |(st_r.csc_flags & st_r.csc_cfg[3:0]) || // [R1] [R2]
                    |(st_r.sev & st_r.smask); // [R6] [R7]

   always_comb begin
      logic [2:0] csc_sel;
      logic [2:0] func_sel;
      logic       tie;
      logic       ser;
      // Tying moves both sources to terminal zero, the line-A interrupt.
      tie          = st_r.route[`PCIRQ_BIT_TIE];
      ser          = st_r.route[`PCIRQ_BIT_SERMODE];
      csc_sel      = tie ? 3'h0 : st_r.route[2:0];
      func_sel     = tie ? 3'h0 : st_r.route[6:4];
      st_nxt       = st_r;
      st_nxt.prev  = cur;
      st_nxt.sb_go = 1'b0;
      st_nxt.func  = func_now; // [R5]
      // Clears come first so that an event in the same cycle survives.
      if (REG.rd && REG.addr == `PCIRQ_OFS_CSC_FLAGS &&
          !st_r.gctl[`PCIRQ_BIT_FCMS]) begin
         st_nxt.csc_flags = 4'h0; // [R19]
      end
      if (REG.wr) begin
         case (REG.addr)
            `PCIRQ_OFS_CSC_FLAGS: begin
               if (st_r.gctl[`PCIRQ_BIT_FCMS]) begin
                  st_nxt.csc_flags = st_r.csc_flags & ~REG.wdata[3:0]; // [R19]
               end
            end
            `PCIRQ_OFS_CSC_CFG:   st_nxt.csc_cfg = REG.wdata;
            `PCIRQ_OFS_GLOBAL:    st_nxt.gctl = REG.wdata;
            `PCIRQ_OFS_SOCK_EVENT: begin
               st_nxt.sev = st_r.sev & ~REG.wdata[3:0]; // [R20]
            end
            `PCIRQ_OFS_SOCK_MASK: st_nxt.smask = REG.wdata[3:0];
            `PCIRQ_OFS_ROUTING:   st_nxt.route = REG.wdata;
            `PCIRQ_OFS_CARD_CTRL: st_nxt.cctl = REG.wdata[7:1];
            `PCIRQ_OFS_SB_INDEX:  st_nxt.sb_index = REG.wdata;
            `PCIRQ_OFS_SB_TARGET: begin
               st_nxt.sb_target = REG.wdata;
               st_nxt.sb_go     = 1'b1; // [R18]
            end
            `PCIRQ_OFS_SB_CTRL:   st_nxt.sb_prot = REG.wdata[`PCIRQ_BIT_SB_PROT];
            default: ;
         endcase
      end
      st_nxt.csc_flags = st_nxt.csc_flags | set_csc;
      st_nxt.sev       = st_nxt.sev | set_sev;
      if (REG.rd) begin
         case (REG.addr)
            `PCIRQ_OFS_CSC_FLAGS:  st_nxt.rdata = {4'h0, st_r.csc_flags};
            `PCIRQ_OFS_CSC_CFG:    st_nxt.rdata = st_r.csc_cfg;
            `PCIRQ_OFS_GLOBAL:     st_nxt.rdata = st_r.gctl;
            `PCIRQ_OFS_SOCK_EVENT: st_nxt.rdata = {4'h0, st_r.sev};
            `PCIRQ_OFS_SOCK_MASK:  st_nxt.rdata = {4'h0, st_r.smask};
            `PCIRQ_OFS_ROUTING:    st_nxt.rdata = st_r.route;
            `PCIRQ_OFS_CARD_CTRL:  st_nxt.rdata = {st_r.cctl, st_r.func};
            `PCIRQ_OFS_SB_DATA:    st_nxt.rdata = sb_data;
            `PCIRQ_OFS_SB_INDEX:   st_nxt.rdata = st_r.sb_index;
            `PCIRQ_OFS_SB_TARGET:  st_nxt.rdata = st_r.sb_target;
            `PCIRQ_OFS_SB_CTRL: begin
               st_nxt.rdata = 8'h00;
               st_nxt.rdata[`PCIRQ_BIT_SB_VALID] = sb_valid;
               st_nxt.rdata[`PCIRQ_BIT_SB_ERR]   = sb_err;
               st_nxt.rdata[`PCIRQ_BIT_SB_PROT]  = st_r.sb_prot;
               st_nxt.rdata[`PCIRQ_BIT_SB_BUSY]  = sb_busy;
            end
            default: st_nxt.rdata = 8'h00;
         endcase
      end
      st_nxt.mfunc = term_onehot(csc_sel, csc_irq) | // [R17] [R21]
                     term_onehot(func_sel, st_r.func && !ser); // [R16]
      st_nxt.serq  = ser && st_r.func; // [R16]
   end

   always_ff @(posedge CLK) begin
      if (!RESETN) begin
         st_r       <= '0;
         st_r.route <= `PCIRQ_RST_ROUTING;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign REG_RDATA                 = st_r.rdata;
   assign MULTIFUNCTION_TERMINALS   = st_r.mfunc;
   assign SERIALIZED_INTERRUPT_LINE = st_r.serq;

   default clocking cb_clk @(posedge CLK);
   endclocking
   default disable iff (!RESETN);

   batt_flag_a: // [R1] [R8]
      assert property (mem && cur.bvd2 != st_r.prev.bvd2
                       |=> st_r.csc_flags[`PCIRQ_BIT_BATT1])
      else $error("Battery line change did not set its flag.");
   ready_flag_a: // [R2] [R9]
      assert property (mem && $changed(cur.ready_ireq)
                       |=> st_r.csc_flags[`PCIRQ_BIT_READY])
      else $error("Ready change did not set its flag.");
   io_release_a: // [R3] [R10]
      assert property (io && !st_r.prev.bvd1_sts && cur.bvd1_sts
                       |-> !set_csc[`PCIRQ_BIT_BATT0])
      else $error("Status-change release raised an event.");
   pwr_flag_a: // [R4] [R14]
      assert property (PWR_DONE && (mem || io)
                       |=> st_r.csc_flags[`PCIRQ_BIT_PWR])
      else $error("Power done did not set the 16-bit flag.");
   func_status_a: // [R5] [R12] [R15]
      assert property (REG.rd && REG.addr == `PCIRQ_OFS_CARD_CTRL
                       ##0 $past(func_now) == 1'b1 && !mem
                       |=> REG_RDATA[`PCIRQ_BIT_FUNC])
      else $error("Functional request not shown in card control.");
   mem_no_func_a: // [R15]
      assert property (mem |=> !st_r.func)
      else $error("Memory card produced a functional request.");
   sock_sts_a: // [R6] [R11]
      assert property (set_sev[`PCIRQ_BIT_CSTS] && st_r.smask[0] |=> ##1
                       MULTIFUNCTION_TERMINALS != 7'h00 ||
                       st_r.route[2:0] == `PCIRQ_TERM_NONE)
      else $error("Socket status change did not reach a terminal.");
   card_detect_a: // [R7] [R13]
      assert property ($changed(cur.cd1_n) |=> st_r.sev[`PCIRQ_BIT_CD1])
      else $error("Card detect change did not set the socket event.");
   read_clear_a: // [R19]
      assert property (REG.rd && REG.addr == `PCIRQ_OFS_CSC_FLAGS &&
                       !st_r.gctl[`PCIRQ_BIT_FCMS] && set_csc == 4'h0
                       |=> st_r.csc_flags == 4'h0)
      else $error("Clear-on-read left a flag set.");
   w1c_sock_a: // [R20]
      assert property (REG.rd == 1'b0 && REG.wr &&
                       REG.addr == `PCIRQ_OFS_SOCK_EVENT &&
                       REG.wdata[0] && !set_sev[0] |=> !st_r.sev[0])
      else $error("Write of one did not clear the socket event.");
   host_irq_a: // [R21]
      assert property (st_r.func && !st_r.route[`PCIRQ_BIT_SERMODE] &&
                       st_r.route[6:4] != `PCIRQ_TERM_NONE
                       |=> MULTIFUNCTION_TERMINALS != 7'h00)
      else $error("Pending request did not drive a terminal.");
   serial_req_a: // [R16]
      assert property (st_r.func && st_r.route[`PCIRQ_BIT_SERMODE]
                       |=> SERIALIZED_INTERRUPT_LINE)
      else $error("Serial mode request did not reach the serial line.");
   idle_term_a: // [R21]
      assert property (st_r.csc_flags == 4'h0 && !st_r.func &&
                       (st_r.sev & st_r.smask) == 4'h0
                       |=> MULTIFUNCTION_TERMINALS == 7'h00)
      else $error("A terminal asserted with nothing pending.");
   w1c_flag_a: // [R19]
      assert property (REG.wr && REG.addr == `PCIRQ_OFS_CSC_FLAGS &&
                       st_r.gctl[`PCIRQ_BIT_FCMS] && REG.wdata[0] &&
                       !set_csc[0] |=> !st_r.csc_flags[0])
      else $error("Write of one did not clear the status flag.");
   sock_keep_a: // [R20]
      assert property (st_r.sev[0] &&
                       !(REG.wr && REG.addr == `PCIRQ_OFS_SOCK_EVENT)
                       |=> st_r.sev[0])
      else $error("Socket event cleared without a write of one.");

   insert_c: cover property ($rose(present) ##[1:20] PWR_DONE);
   serial_c: cover property (SERIALIZED_INTERRUPT_LINE);
   func_c:   cover property (st_r.func && MULTIFUNCTION_TERMINALS != 7'h00);
   clear_c:  cover property (st_r.csc_flags != 4'h0 ##1
                             st_r.csc_flags == 4'h0);
endmodule // pcirq_events
`default_nettype wire

// ### tb/pcirq_socket_model.sv
// Purpose: Socket pins and serial-bus engine facing the event block.
// Assumes: The bench sets pin levels through put.
// Notes:   Done delay is variable so prompt and slow answers both occur.
`timescale 1ns/1ps
`default_nettype none
module pcirq_socket_model
   import pcirq_pkg::*;
(
   input  wire logic          CLK,
   input  wire logic          RESETN,
   input  wire pcirq_sb_req_s SB_REQ,
   output pcirq_pins_s        pins,
   output pcirq_sb_rsp_s      rsp
);
   int         dly = 1;
   int         cnt = 0;
   logic [7:0] noise = 8'h5A;
   initial pins = 5'h01;
   initial rsp = '0;
   task automatic put(input pcirq_pins_s np);
      @(negedge CLK);
      pins = np;
   endtask
   // Read data means nothing without done, so it churns every cycle.
   always @(posedge CLK) begin
      noise <= ~noise;
      rsp   <= '{1'h0, 1'h0, noise};
      if (!RESETN) begin
         cnt <= 0;
      end else if (SB_REQ.start) begin
         cnt <= dly;
      end else if (cnt == 1) begin
         cnt <= 0;
         rsp <= '{1'h1, 1'h0, ~SB_REQ.target};
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule // pcirq_socket_model
`default_nettype wire

// ### tb/pcirq_events_tb.sv
// Purpose: Self-checking bench for the socket interrupt event block.
// Assumes: Register reads answer on the clock edge that samples the read.
// Notes:   Pin changes are given six cycles to reach flags and terminals.
`timescale 1ns/1ps
`default_nettype none
module pcirq_events_tb;
   import pcirq_pkg::*;
   logic          CLK = 1'h0;
   logic          RESETN = 1'h0;
   pcirq_pins_s   pins;
   pcirq_card_e   card = PCIRQ_CT_NONE;
   logic          pwr = 1'h0;
   pcirq_reg_s    rq = '0;
   logic [7:0]    rdata;
   logic [6:0]    mft;
   logic          serl;
   pcirq_sb_req_s sb_req;
   pcirq_sb_req_s seen = '0;
   pcirq_sb_rsp_s sb_rsp;
   pcirq_pins_s   p = 5'h01;
   int            n_start = 0;
   int            n_fail = 0;
   int            samples_checked = 0;
   logic [7:0]    v;

   pcirq_events pcirq_events_i (.CLK(CLK), .RESETN(RESETN),
      .CARD_PINS(pins), .CARD_TYPE(card), .PWR_DONE(pwr), .REG(rq),
      .REG_RDATA(rdata), .MULTIFUNCTION_TERMINALS(mft),
      .SERIALIZED_INTERRUPT_LINE(serl), .SB_REQ(sb_req), .SB_RSP(sb_rsp));
   pcirq_socket_model pcirq_socket_model_i (.CLK(CLK), .RESETN(RESETN),
      .SB_REQ(sb_req), .pins(pins), .rsp(sb_rsp));

   initial forever #10 CLK = ~CLK;
   always @(posedge CLK) begin
      if (sb_req.start) begin
         n_start++;
         seen <= sb_req;
      end
   end

   task automatic final_report;
      $display("Checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input string name, input logic [7:0] exp,
                        input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic access(input logic wr, input logic [7:0] a,
                         input logic [7:0] d);
      @(negedge CLK);
      rq = '{wr, !wr, a, d};
      @(negedge CLK);
      rq = '0;
      repeat (2) @(negedge CLK);
   endtask
   task automatic expect_reg(input logic [7:0] a, input logic [7:0] exp);
      access(1'h0, a, 8'h00);
      check($sformatf("register %h", a), exp, rdata);
   endtask
   task automatic term(input logic [6:0] exp);
      check("terminals", {1'h0, exp}, {1'h0, mft});
   endtask
   task automatic pin;
      pcirq_socket_model_i.put(p);
      repeat (6) @(negedge CLK);
   endtask
   task automatic pulse_pwr;
      @(negedge CLK);
      pwr = 1'h1;
      @(negedge CLK);
      pwr = 1'h0;
      repeat (3) @(negedge CLK);
   endtask
   // Busy is polled under a bound; a hung engine ends the run.
   task automatic sb_run(input logic [7:0] tgt);
      int i;
      access(1'h1, 8'hB2, tgt);
      v = 8'h20;
      for (i = 0; i < 50 && v[5] !== 1'h0; i++) begin
         access(1'h0, 8'hB3, 8'h00);
         v = rdata;
      end
      if (v[5] !== 1'h0) begin
         check("serial-bus busy", 8'h00, {7'h00, v[5]});
         final_report();
      end
   endtask

   initial begin
      repeat (10) @(negedge CLK);
      RESETN = 1'h1;
      expect_reg(8'h8C, 8'h77);
      expect_reg(8'h04, 8'h00);
      access(1'h1, 8'h33, 8'hFF);
      expect_reg(8'h33, 8'h00);
      // Memory card, status change routed to terminal 2.
      card = PCIRQ_CT_MEM16;
      access(1'h1, 8'h8C, 8'h72);
      access(1'h1, 8'h05, 8'h0F);
      p.bvd1_sts = 1'h1; pin();
      term(7'h04);
      expect_reg(8'h04, 8'h01);
      expect_reg(8'h04, 8'h00);
      term(7'h00);
      p.bvd2 = 1'h1; pin();
      expect_reg(8'h04, 8'h02);
      p.ready_ireq = 1'h0; pin();
      expect_reg(8'h91, 8'h00);
      expect_reg(8'h04, 8'h04);
      p.ready_ireq = 1'h1; pin();
      expect_reg(8'h04, 8'h04);
      pulse_pwr();
      expect_reg(8'h04, 8'h08);
      access(1'h1, 8'h05, 8'h00);
      p.bvd1_sts = 1'h0; pin();
      term(7'h00);
      expect_reg(8'h04, 8'h01);
      // I/O card, functional routed to terminal 5.
      card = PCIRQ_CT_IO16;
      access(1'h1, 8'h05, 8'h0F);
      access(1'h1, 8'h8C, 8'h52);
      p.bvd1_sts = 1'h1; pin();
      expect_reg(8'h04, 8'h00);
      p.bvd1_sts = 1'h0; pin();
      term(7'h04);
      expect_reg(8'h04, 8'h01);
      pulse_pwr();
      expect_reg(8'h04, 8'h08);
      p.ready_ireq = 1'h0; pin();
      access(1'h1, 8'h05, 8'h00);
      term(7'h20);
      expect_reg(8'h91, 8'h01);
      access(1'h1, 8'h8C, 8'h7F);
      term(7'h01);
      access(1'h1, 8'h8C, 8'hF7);
      term(7'h00);
      check("serial line", 8'h01, {7'h00, serl});
      p.ready_ireq = 1'h1; pin();
      check("serial line", 8'h00, {7'h00, serl});
      // Write-one-to-clear mode.
      access(1'h1, 8'h1E, 8'h04);
      p.bvd1_sts = 1'h1; pin();
      p.bvd1_sts = 1'h0; pin();
      expect_reg(8'h04, 8'h01);
      expect_reg(8'h04, 8'h01);
      access(1'h1, 8'h04, 8'h01);
      expect_reg(8'h04, 8'h00);
      // CardBus card, status change routed to terminal 3.
      card = PCIRQ_CT_CARDBUS;
      access(1'h1, 8'h8C, 8'h73);
      access(1'h1, 8'h61, 8'h0F);
      p.bvd1_sts = 1'h1; pin();
      term(7'h08);
      expect_reg(8'h60, 8'h01);
      expect_reg(8'h60, 8'h01);
      access(1'h1, 8'h60, 8'h01);
      expect_reg(8'h60, 8'h00);
      p.cd1_n = 1'h1; pin();
      p.cd1_n = 1'h0; pin();
      expect_reg(8'h60, 8'h02);
      p.cd2_n = 1'h1; pin();
      p.cd2_n = 1'h0; pin();
      expect_reg(8'h60, 8'h06);
      pulse_pwr();
      expect_reg(8'h60, 8'h0E);
      access(1'h1, 8'h60, 8'h0F);
      access(1'h1, 8'h61, 8'h00);
      p.bvd1_sts = 1'h0; pin();
      p.bvd1_sts = 1'h1; pin();
      term(7'h00);
      expect_reg(8'h60, 8'h01);
      // Serial-bus write, then a slow read.
      access(1'h1, 8'hB0, 8'h3C);
      access(1'h1, 8'hB1, 8'h12);
      access(1'h1, 8'hB3, 8'h08);
      sb_run(8'hA0);
      check("start count", 8'h01, 8'(n_start));
      check("target", 8'hA0, seen.target);
      check("index", 8'h12, seen.index);
      check("data", 8'h3C, seen.data);
      check("protocol", 8'h01, {7'h00, seen.prot});
      pcirq_socket_model_i.dly = 12;
      sb_run(8'hA1);
      check("start count", 8'h02, 8'(n_start));
      check("target", 8'hA1, seen.target);
      expect_reg(8'hB0, 8'h5E);
      expect_reg(8'hB3, 8'h09);
      access(1'h1, 8'h91, 8'hAB);
      expect_reg(8'h91, 8'hAA);
      final_report();
   end
endmodule // pcirq_events_tb
`default_nettype wire
